// >>> rtl/umx_pkg.sv
package umx_pkg;

    // -----------------------------------------------------------------
    // instruction encoding
    // -----------------------------------------------------------------
    localparam logic [7:0] OPC_MUL_LIT      = 8'h0D;   // 0000 1101 kkkk kkkk
    localparam logic [6:0] OPC_MUL_FILE     = 7'h01;   // 0000 001a ffff ffff
    localparam int         OPC_HI_POS       = 8;
    localparam int         BANK_BIT_POS     = 8;
    localparam logic [7:0] ILO_LIMIT        = 8'h5F;   // indexed offset for f <= 95
    localparam logic [7:0] ACCESS_SPLIT     = 8'h60;   // access bank low/high split
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;

    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [7:0]  PROD_RESET = 8'h00;
    localparam logic [11:0] ADDR_RESET = 12'h000;

    // -----------------------------------------------------------------
    // quarter phases of one instruction cycle
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        UMX_Q1 = 4'b0001,
        UMX_Q2 = 4'b0010,
        UMX_Q3 = 4'b0100,
        UMX_Q4 = 4'b1000
    } umx_phase_e;

    // decoded instruction
    typedef struct packed {
        logic       is_lit;
        logic       is_file;
        logic [7:0] operand;
        logic       bank_sel;
    } umx_decode_s;

    // product pair
    typedef struct packed {
        logic [7:0] high_byte;
        logic [7:0] low_byte;
    } umx_product_s;

endpackage

// >>> rtl/umx_mult8.sv
`timescale 1ns/1ps
`default_nettype none

// registered 8x8 unsigned multiplier
module umx_mult8 (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        enable,
    input  wire logic [7:0]  op_a,
    input  wire logic [7:0]  op_b,
    output logic [15:0]      product
);

    // -----------------------------------------------------------------
    // product register
    // -----------------------------------------------------------------
    logic [15:0] raw_product;

    assign raw_product = 16'(op_a) * 16'(op_b);

    // capture on enable
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            product <= 16'h0000;
        end else if (enable) begin
            product <= raw_product;
        end
    end

endmodule // umx_mult8

`default_nettype wire

// >>> rtl/umx_mul_unit.sv
`timescale 1ns/1ps
`default_nettype none

module umx_mul_unit (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic [7:0]  accumulator,
    input  wire logic [3:0]  bank_selector,
    input  wire logic        ext_set_enable,
    input  wire logic [11:0] index_base,
    input  wire logic [7:0]  file_rdata,
    output logic [11:0]      file_addr,
    output logic             file_rd,
    output logic [7:0]       product_high_byte,
    output logic [7:0]       product_low_byte,
    output logic             product_we,
    output logic             busy,
    output logic             status_we
);

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    umx_pkg::umx_phase_e   phase;
    umx_pkg::umx_phase_e   next_phase;
    umx_pkg::umx_decode_s  dec;
    umx_pkg::umx_decode_s  next_dec;
    umx_pkg::umx_product_s prod_split;
    logic [7:0]            opc_byte;
    logic [6:0]            opc_file_bits;
    logic [7:0]            low_field;
    logic                  bank_field;
    logic                  hit_lit;
    logic                  hit_file;
    logic                  next_mul;
    logic                  mul_active;
    logic                  in_q1;
    logic                  in_q2;
    logic                  in_q3;
    logic                  in_q4;
    logic                  start_cycle;
    logic                  use_ilo;
    logic                  low_access;
    logic [11:0]           ilo_addr;
    logic [11:0]           banked_addr;
    logic [11:0]           access_addr;
    logic [11:0]           eff_addr;
    logic [7:0]            operand_b;
    logic [7:0]            operand_q;
    logic                  mult_en;
    logic                  write_now;
    logic                  next_file_rd;
    logic                  next_busy;
    logic [15:0]           mult_out;

    // instruction fields
    assign opc_byte      = instr_word[15:umx_pkg::OPC_HI_POS];
    assign opc_file_bits = instr_word[15:umx_pkg::OPC_HI_POS + 1];
    assign low_field     = instr_word[7:0];
    assign bank_field    = instr_word[umx_pkg::BANK_BIT_POS];

    // opcode matching
    assign hit_lit  = (opc_byte == umx_pkg::OPC_MUL_LIT);
    assign hit_file = (opc_file_bits == umx_pkg::OPC_MUL_FILE);

    // decoded word, taken only at the q1 edge
    assign next_dec.is_lit   = instr_valid && hit_lit;
    assign next_dec.is_file  = instr_valid && hit_file;
    assign next_dec.operand  = low_field;
    assign next_dec.bank_sel = bank_field;
    assign next_mul          = next_dec.is_lit || next_dec.is_file;
    assign mul_active        = dec.is_lit || dec.is_file;

    // -----------------------------------------------------------------
    // quarter flags
    // -----------------------------------------------------------------
    assign in_q1       = (phase == umx_pkg::UMX_Q1);
    assign in_q2       = (phase == umx_pkg::UMX_Q2);
    assign in_q3       = (phase == umx_pkg::UMX_Q3);
    assign in_q4       = (phase == umx_pkg::UMX_Q4);
    assign start_cycle = in_q1 && (next_phase == umx_pkg::UMX_Q2);

    // -----------------------------------------------------------------
    // file address generation
    // -----------------------------------------------------------------
    // indexed offset only with extended set, bank bit clear, low offsets
    assign use_ilo     = ext_set_enable && !dec.bank_sel
                         && (dec.operand <= umx_pkg::ILO_LIMIT);
    assign low_access  = (dec.operand < umx_pkg::ACCESS_SPLIT);
    assign ilo_addr    = index_base + {4'h0, dec.operand};
    assign banked_addr = {bank_selector, dec.operand};
    assign access_addr = low_access ? {umx_pkg::ACCESS_LOW_BANK, dec.operand}
                                    : {umx_pkg::ACCESS_HIGH_BANK, dec.operand};
    assign eff_addr    = use_ilo      ? ilo_addr :
                         dec.bank_sel ? banked_addr : access_addr;

    // -----------------------------------------------------------------
    // operand and strobe selection
    // -----------------------------------------------------------------
    // second operand: literal or file data
    assign operand_b    = dec.is_lit ? dec.operand : file_rdata;
    assign mult_en      = in_q3 && mul_active;
    assign write_now    = in_q4 && mul_active;
    assign next_file_rd = start_cycle && next_dec.is_file;
    assign next_busy    = (next_phase != umx_pkg::UMX_Q1)
                          && (in_q1 ? next_mul : mul_active);

    // -----------------------------------------------------------------
    // quarter sequencer
    // -----------------------------------------------------------------
    always_comb begin
        unique case (phase)
            umx_pkg::UMX_Q1: next_phase = umx_pkg::UMX_Q2;
            umx_pkg::UMX_Q2: next_phase = umx_pkg::UMX_Q3;
            umx_pkg::UMX_Q3: next_phase = umx_pkg::UMX_Q4;
            umx_pkg::UMX_Q4: next_phase = umx_pkg::UMX_Q1;
            default:         next_phase = umx_pkg::UMX_Q1;
        endcase
    end

    // phase advances every clock; decode latches at q1
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase <= umx_pkg::UMX_Q1;
            dec   <= '0;
        end else begin
            phase <= next_phase;
            if (in_q1) begin
                dec <= next_dec;
            end
        end
    end

    // operand read at q2; accumulator only read, never written
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            operand_q <= umx_pkg::PROD_RESET;
            file_addr <= umx_pkg::ADDR_RESET;
            file_rd   <= 1'b0;
        end else begin
            file_rd <= next_file_rd;
            if (in_q2) begin
                file_addr <= eff_addr;
                operand_q <= operand_b;
            end
        end
    end

    // -----------------------------------------------------------------
    // multiply at q3
    // -----------------------------------------------------------------
    umx_mult8 umx_mult8_inst (
        .clock   (clock),
        .sys_rst (sys_rst),
        .enable  (mult_en),
        .op_a    (accumulator),
        .op_b    (operand_q),
        .product (mult_out)
    );

    // -----------------------------------------------------------------
    // product write at q4
    // -----------------------------------------------------------------
    assign prod_split = mult_out;

    // product pair moves only on a multiply's q4 edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            product_high_byte <= umx_pkg::PROD_RESET;
            product_low_byte  <= umx_pkg::PROD_RESET;
        end else if (write_now) begin
            product_high_byte <= prod_split.high_byte;
            product_low_byte  <= prod_split.low_byte;
        end
    end

    // strobes; the status write is never raised
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            product_we <= 1'b0;
            busy       <= 1'b0;
            status_we  <= 1'b0;
        end else begin
            product_we <= write_now;
            busy       <= next_busy;
            status_we  <= 1'b0;
        end
    end

endmodule // umx_mul_unit

`default_nettype wire

// >>> tb/umx_mul_unit_props.sv
`timescale 1ns/1ps
`default_nettype none

module umx_mul_unit_props (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [7:0]  accumulator,
    input wire logic [3:0]  bank_selector,
    input wire logic        ext_set_enable,
    input wire logic [11:0] index_base,
    input wire logic [7:0]  file_rdata,
    input wire logic [11:0] file_addr,
    input wire logic        file_rd,
    input wire logic [7:0]  product_high_byte,
    input wire logic [7:0]  product_low_byte,
    input wire logic        product_we,
    input wire logic        busy,
    input wire logic        status_we
);
    // ---------------------------------------------
    // timing and address checks
    // ---------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // read quarter leads to the write pulse
    sequence s_done;
        ##3 product_we;
    endsequence
    chk_flags_quiet: assert property (!status_we)
        else $error("status write seen");
    chk_we_single: assert property (product_we |=> !product_we)
        else $error("write pulse too long");
    chk_prod_flagged: assert property (
        $changed({product_high_byte, product_low_byte}) |-> product_we)
        else $error("product moved without write");
    chk_read_done: assert property (file_rd |-> s_done)
        else $error("no write three clocks after read");
    chk_read_file: assert property (file_rd |->
        $past(instr_valid) && $past(instr_word[15:9]) == umx_pkg::OPC_MUL_FILE)
        else $error("read on non file opcode");
    chk_bank_addr: assert property (file_rd && $past(instr_word[8]) |=>
        file_addr == {$past(bank_selector), $past(instr_word[7:0], 2)})
        else $error("bank address");
    chk_index_addr: assert property (file_rd && !$past(instr_word[8]) && ext_set_enable &&
        $past(instr_word[7:0]) <= 8'h5F |=>
        file_addr == $past(index_base) + 12'($past(instr_word[7:0], 2)))
        else $error("indexed address");
    chk_access_addr: assert property (file_rd && !$past(instr_word[8]) &&
        !(ext_set_enable && $past(instr_word[7:0]) <= 8'h5F) |=>
        file_addr == {($past(instr_word[7:0], 2) < 8'h60 ? 4'h0 : 4'hF), $past(instr_word[7:0], 2)})
        else $error("access address");
    // busy covers the three quarters after the capture edge
    sequence s_busy_run;
        busy ##1 busy ##1 busy;
    endsequence
    chk_busy_span: assert property (file_rd |-> s_busy_run)
        else $error("busy too short");
    chk_we_busy: assert property (product_we |-> $past(busy))
        else $error("write without busy");
endmodule // umx_mul_unit_props

bind umx_mul_unit umx_mul_unit_props umx_mul_unit_props_inst (
    .clock             (clock),
    .sys_rst           (sys_rst),
    .instr_valid       (instr_valid),
    .instr_word        (instr_word),
    .accumulator       (accumulator),
    .bank_selector     (bank_selector),
    .ext_set_enable    (ext_set_enable),
    .index_base        (index_base),
    .file_rdata        (file_rdata),
    .file_addr         (file_addr),
    .file_rd           (file_rd),
    .product_high_byte (product_high_byte),
    .product_low_byte  (product_low_byte),
    .product_we        (product_we),
    .busy              (busy),
    .status_we         (status_we)
);

`default_nettype wire

// >>> tb/tb_umx_mul_unit.sv
`timescale 1ns/1ps
`default_nettype none

module tb_umx_mul_unit;
    logic        clock = 1'h0;
    logic        sys_rst = 1'h1;
    logic        instr_valid = 1'h0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0]  accumulator = 8'h00;
    logic [3:0]  bank_selector = 4'h5;
    logic        ext_set_enable = 1'h0;
    logic [11:0] index_base = 12'h300;
    logic [7:0]  file_rdata = 8'h00;
    logic [11:0] file_addr;
    logic        file_rd;
    logic [7:0]  product_high_byte;
    logic [7:0]  product_low_byte;
    logic        product_we;
    logic        busy;
    logic        status_we;
    int          fails = 0;
    int          checked = 0;

    umx_mul_unit umx_mul_unit_inst (
        .clock             (clock),
        .sys_rst           (sys_rst),
        .instr_valid       (instr_valid),
        .instr_word        (instr_word),
        .accumulator       (accumulator),
        .bank_selector     (bank_selector),
        .ext_set_enable    (ext_set_enable),
        .index_base        (index_base),
        .file_rdata        (file_rdata),
        .file_addr         (file_addr),
        .file_rd           (file_rd),
        .product_high_byte (product_high_byte),
        .product_low_byte  (product_low_byte),
        .product_we        (product_we),
        .busy              (busy),
        .status_we         (status_we)
    );

    // ---------------------------------------------
    // clock, helpers and scenarios
    // ---------------------------------------------
    initial forever #50 clock = ~clock;

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one instruction cycle, inputs held through all four quarters
    task automatic op(input logic [15:0] w, input logic v,
                      input logic [7:0] acc, input logic [7:0] fd);
        logic rd_exp;
        logic busy_exp;
        rd_exp = v && (w[15:9] == umx_pkg::OPC_MUL_FILE);
        busy_exp = rd_exp || (v && (w[15:8] == umx_pkg::OPC_MUL_LIT));
        instr_word = w;
        instr_valid = v;
        accumulator = acc;
        file_rdata = fd;
        @(posedge clock);
        #1;
        cmp({14'h0000, busy, file_rd}, {14'h0000, busy_exp, rd_exp});
        repeat (3) @(posedge clock);
        #1;
        cmp({15'h0000, status_we}, 16'h0000);
        cmp({15'h0000, busy}, 16'h0000);
    endtask

    task automatic t_literal;
        op(16'h0DC4, 1'h1, 8'hE2, 8'h00);
        cmp({product_high_byte, product_low_byte}, 16'hAD08);
        cmp({15'h0000, product_we}, 16'h0001);
        op(16'h0DFF, 1'h1, 8'hFF, 8'h00);
        cmp({product_high_byte, product_low_byte}, 16'hFE01);
        op(16'h0D00, 1'h1, 8'h37, 8'h00);
        cmp({product_high_byte, product_low_byte}, 16'h0000);
    endtask

    task automatic t_file;
        op(16'h0342, 1'h1, 8'hC4, 8'hB5);
        cmp({product_high_byte, product_low_byte}, 16'h8A94);
        cmp({4'h0, file_addr}, 16'h0542);
        op(16'h0290, 1'h1, 8'h10, 8'h10);
        cmp({4'h0, file_addr}, 16'h0F90);
        cmp({product_high_byte, product_low_byte}, 16'h0100);
        op(16'h0220, 1'h1, 8'h03, 8'h81);
        cmp({4'h0, file_addr}, 16'h0020);
        cmp({product_high_byte, product_low_byte}, 16'h0183);
    endtask

    task automatic t_index;
        ext_set_enable = 1'h1;
        op(16'h025F, 1'h1, 8'h02, 8'h40);
        cmp({4'h0, file_addr}, 16'h035F);
        op(16'h0260, 1'h1, 8'h02, 8'h40);
        cmp({4'h0, file_addr}, 16'h0F60);
        op(16'h035F, 1'h1, 8'h02, 8'h40);
        cmp({4'h0, file_addr}, 16'h055F);
    endtask

    // foreign opcode and an unqualified word leave the pair alone
    task automatic t_refuse;
        op(16'h0E12, 1'h1, 8'h05, 8'h00);
        op(16'h0D12, 1'h0, 8'h05, 8'h00);
        cmp({product_high_byte, product_low_byte}, 16'h0080);
        cmp({15'h0000, product_we}, 16'h0000);
    endtask

    task automatic give_verdict;
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clock);
        #1;
        sys_rst = 1'h0;
        cmp({product_high_byte, product_low_byte}, 16'h0000);
        cmp({busy, product_we, file_rd, status_we, file_addr}, 16'h0000);
        t_literal();
        t_file();
        t_index();
        t_refuse();
        give_verdict();
    end

    // hang guard, far beyond the ~64 cycles of reset and traffic
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule // tb_umx_mul_unit

`default_nettype wire
